// ==== logic/upr_cfg_store.sv ====
`timescale 1ns/1ps
`default_nettype none

// Small store for the link configuration saved over hibernate.
module upr_cfg_store
#(
  parameter int WIDTH = 9,
  parameter int DEPTH = 2
)
(
  input  wire logic                     i_clk,
  input  wire logic                     i_ce,
  input  wire logic                     i_we,
  input  wire logic [$clog2(DEPTH)-1:0] i_addr,
  input  wire logic [WIDTH-1:0]         i_wdata,
  output logic      [WIDTH-1:0]         o_rdata
);

  logic [WIDTH-1:0] mem_reg [DEPTH];

  initial
  begin
    if (DEPTH < 2 || WIDTH < 1)
      $error("upr_cfg_store: bad size");
  end

  always_ff @(posedge i_clk)
  begin
    if (i_ce)
    begin
      if (i_we)
        mem_reg[i_addr] <= i_wdata;
      o_rdata <= mem_reg[i_addr];
    end
  end

endmodule

`default_nettype wire

// ==== logic/upr_ctrl.sv ====
//
// Operation
// - Boot unit 30h is read-only, mirrors selected.
// - Active boot attribute 01h unit A, 02h B.
// - Accept four reference clocks, default 26 MHz.
// - Reference clock selection is write-once.
// - Power-mode write starts UniPro mode switch.
// - Refuse HS series change between A and B.
// - Save link configuration on hibernate, restore after.
// - Power changes go to D0h; report state.
// - Decode start stop unit command fields.
// - Condition 01h enters Active; idles after quiet.
// - Idle only from Active; wakes on task.
// - Condition 02h from Active enters Sleep.
// - Condition 03h from Active/Sleep enters PowerDown.
// - Auto sleep after 10 ms without command.
// - Resets pick Pre-Sleep or Pre-Active state.
// - Each reset type clears its own scope.
// - Hardware reset pin discards volatile state.
// - Endpoint reset discards volatile state.
// - Function 08h clears addressed unit queue only.
// - Task request fields: unit, tag, function, length.
//
`timescale 1ns/1ps
`default_nettype none

`include "upr_map.svh"

module upr_ctrl
#(
  parameter int AUTO_SLEEP_CYC = `UPR_AUTO_SLEEP_CYC,
  parameter int IDLE_CYC       = `UPR_IDLE_CYC_DEFAULT,
  parameter int NUM_UNITS      = `UPR_NUM_UNITS
)
(
  input  wire logic                     i_clk,
  input  wire logic                     i_rst,
  input  wire logic                     i_ce,
  input  wire logic                     i_rst_pin_n,
  input  wire logic                     i_endpoint_reset,
  input  wire logic                     i_unipro_reset,
  input  wire logic [7:0]               i_initial_power_state,
  input  wire logic [7:0]               i_boot_feature_enable,
  input  wire logic [7:0]               i_unit_boot_select [NUM_UNITS],
  input  wire logic                     i_attr_wr,
  input  wire logic [7:0]               i_attr_idn,
  input  wire logic [7:0]               i_attr_wdata,
  input  wire logic                     i_ssu_valid,
  input  wire upr_pkg::upr_ssu_t        i_ssu,
  input  wire logic                     i_tmr_valid,
  input  wire upr_pkg::upr_tmr_t        i_tmr,
  input  wire logic                     i_cmd_valid,
  input  wire logic [7:0]               i_cmd_unit,
  input  wire logic                     i_cmd_write,
  input  wire logic                     i_task_pending,
  input  wire logic                     i_dme_set_pwr_mode,
  input  wire upr_pkg::upr_link_cfg_t   i_link_req,
  input  wire logic                     i_hib_enter,
  input  wire logic                     i_hib_exit,
  output logic                          o_ssu_done,
  output logic                          o_ssu_error,
  output logic                          o_tmr_done,
  output logic                          o_tmr_error,
  output logic                          o_cmd_reject,
  output logic [7:0]                    o_boot_map_unit,
  output logic                          o_boot_map_valid,
  output logic [7:0]                    o_active_boot_unit,
  output logic [1:0]                    o_ref_clk_freq_select,
  output logic [7:0]                    o_present_power_state,
  output upr_pkg::upr_state_t           o_state,
  output logic                          o_core_supply_off_ok,
  output logic                          o_auto_sleep,
  output logic                          o_discard_cache,
  output upr_pkg::upr_link_cfg_t        o_link_cfg,
  output logic                          o_link_change_err,
  output logic                          o_hibernated,
  output logic [NUM_UNITS-1:0]          o_queue_clear,
  output logic                          o_volatile_clear,
  output logic                          o_poweron_clear,
  output logic                          o_link_stack_clear
);

  import upr_pkg::*;

  initial
  begin
    if (NUM_UNITS < 1 || NUM_UNITS > 8 || AUTO_SLEEP_CYC < 2 || IDLE_CYC < 2)
      $error("upr_ctrl: unsupported parameter");
  end

  // ----------------------------------------------------------------------
  // Reset sources
  // ----------------------------------------------------------------------

  logic pin_prev_reg;
  wire  hw_reset   = pin_prev_reg & ~i_rst_pin_n;
  wire  full_reset = i_rst | hw_reset;
  wire  link_reset = full_reset | i_endpoint_reset | i_unipro_reset;
  wire  unit_reset_req = i_tmr_valid && (i_tmr.function_code == `UPR_TMF_UNIT_RESET);
  wire  tmr_fmt_ok = (i_tmr.data_seg_len == `UPR_DSL_ZERO)
                     && (i_tmr.unit < 8'(NUM_UNITS));

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------

  function automatic logic [7:0] state_code(input upr_state_t s);
    case (s)
      UPR_ST_PRE_ACTIVE:    state_code = 8'h10;
      UPR_ST_ACTIVE:        state_code = 8'h11;
      UPR_ST_IDLE:          state_code = 8'h22;
      UPR_ST_PRE_SLEEP:     state_code = 8'h20;
      UPR_ST_SLEEP:         state_code = 8'h21;
      UPR_ST_PRE_POWERDOWN: state_code = 8'h30;
      default:              state_code = 8'h33;
    endcase
  endfunction

  function automatic logic is_boot_id(input logic [7:0] v);
    is_boot_id = (v == `UPR_BOOT_UNIT_A) || (v == `UPR_BOOT_UNIT_B);
  endfunction

  // ----------------------------------------------------------------------
  // Boot unit mapping and attributes
  // ----------------------------------------------------------------------

  logic [7:0] active_boot_reg;
  logic [1:0] ref_clk_reg;
  logic       ref_clk_written_reg;
  logic       boot_allowed_reg;
  logic       tmr_ok;

  wire wr_boot   = i_attr_wr && (i_attr_idn == `UPR_IDN_ACTIVE_BOOT)
                   && (i_attr_wdata == 8'h00 || is_boot_id(i_attr_wdata));
  wire wr_refclk = i_attr_wr && (i_attr_idn == `UPR_IDN_REF_CLK)
                   && !ref_clk_written_reg && (i_attr_wdata < 8'h04);

  logic [7:0] boot_hit_unit;
  logic       boot_hit;
  always_comb
  begin
    boot_hit_unit = 8'h00;
    boot_hit      = 1'b0;
    for (int u = 0; u < NUM_UNITS; u++)
    begin
      if (is_boot_id(active_boot_reg) && i_unit_boot_select[u] == active_boot_reg && !boot_hit)
      begin
        boot_hit_unit = 8'(u);
        boot_hit      = 1'b1;
      end
    end
  end

  wire boot_on = boot_hit && boot_allowed_reg
                 && (i_boot_feature_enable == `UPR_BOOT_FEAT_ON);
  wire cmd_to_boot = i_cmd_valid && (i_cmd_unit == `UPR_WLUN_BOOT);
  wire cmd_reject  = cmd_to_boot && (i_cmd_write || !boot_on);

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      ref_clk_reg <= `UPR_REFCLK_DEFAULT;
    else if (i_ce && wr_refclk)
      ref_clk_reg <= i_attr_wdata[1:0];
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      pin_prev_reg <= 1'b1;
    else if (i_ce)
      pin_prev_reg <= i_rst_pin_n;
  end

  always_ff @(posedge i_clk)
  begin
    if (full_reset)
      ref_clk_written_reg <= 1'b0;
    else if (i_ce && wr_refclk)
      ref_clk_written_reg <= 1'b1;
  end

  always_ff @(posedge i_clk)
  begin
    if (link_reset)
    begin
      active_boot_reg  <= 8'h00;
      boot_allowed_reg <= 1'b1;
    end
    else if (i_ce)
    begin
      if (wr_boot)
        active_boot_reg <= i_attr_wdata;
      if (tmr_ok)
        boot_allowed_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // UFS power state machine
  // ----------------------------------------------------------------------

  upr_state_t state_reg;
  upr_state_t state_next;
  logic [31:0] quiet_reg;
  logic [31:0] idle_cnt_reg;

  wire ssu_dev  = i_ssu_valid && (i_ssu.unit == `UPR_WLUN_DEVICE);
  wire [3:0] pc = i_ssu.power_cond;
  wire in_act   = (state_reg == UPR_ST_ACTIVE) || (state_reg == UPR_ST_IDLE);
  wire go_act   = ssu_dev && pc == `UPR_PC_ACTIVE;
  wire go_slp   = ssu_dev && pc == `UPR_PC_SLEEP && in_act;
  wire go_pd    = ssu_dev && pc == `UPR_PC_POWERDOWN
                  && (in_act || state_reg == UPR_ST_SLEEP);
  wire ssu_ok   = ssu_dev && !i_ssu.load_eject && (go_act || go_slp || go_pd);
  wire ssu_err  = i_ssu_valid && !ssu_ok;
  wire cmd_seen = i_cmd_valid | i_ssu_valid | i_tmr_valid;
  wire init_act = (i_initial_power_state == `UPR_INIT_ACTIVE);

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      UPR_ST_PRE_ACTIVE:    state_next = UPR_ST_ACTIVE;
      UPR_ST_PRE_SLEEP:     state_next = UPR_ST_SLEEP;
      UPR_ST_PRE_POWERDOWN: state_next = UPR_ST_POWERDOWN;
      UPR_ST_ACTIVE:
      begin
        if (idle_cnt_reg >= 32'(IDLE_CYC - 1))
          state_next = UPR_ST_IDLE;
      end
      UPR_ST_IDLE:
      begin
        if (i_task_pending || cmd_seen)
          state_next = UPR_ST_ACTIVE;
      end
      default:
        state_next = state_reg;
    endcase
    if (ssu_ok)
    begin
      if (go_act && state_reg != UPR_ST_ACTIVE)
        state_next = UPR_ST_PRE_ACTIVE;
      else if (go_slp)
        state_next = UPR_ST_PRE_SLEEP;
      else if (go_pd)
        state_next = UPR_ST_PRE_POWERDOWN;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (link_reset)
      state_reg <= init_act ? UPR_ST_PRE_ACTIVE : UPR_ST_PRE_SLEEP;
    else if (i_ce)
      state_reg <= state_next;
  end

  always_ff @(posedge i_clk)
  begin
    if (link_reset)
      idle_cnt_reg <= 32'h0000_0000;
    else if (i_ce)
      idle_cnt_reg <= (state_reg != UPR_ST_ACTIVE || cmd_seen || i_task_pending)
                      ? 32'h0000_0000 : idle_cnt_reg + 32'h0000_0001;
  end

  // Counts from the last command; saturates so the flag stays steady.
  always_ff @(posedge i_clk)
  begin
    if (link_reset)
      quiet_reg <= 32'h0000_0000;
    else if (i_ce)
    begin
      if (cmd_seen)
        quiet_reg <= 32'h0000_0000;
      else if (quiet_reg < 32'(AUTO_SLEEP_CYC))
        quiet_reg <= quiet_reg + 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------------
  // UniPro link configuration and hibernate
  // ----------------------------------------------------------------------

  upr_link_cfg_t link_reg;
  logic          hib_reg;
  logic          restore_reg;
  upr_link_cfg_t saved_cfg;

  // Direct moves between HS series A and B are refused; PWM sources are free.
  wire series_bad = link_reg.hs && i_link_req.hs
                    && (link_reg.series_b != i_link_req.series_b);
  wire mode_ok    = i_dme_set_pwr_mode && !series_bad && !hib_reg;

  upr_cfg_store #(.WIDTH($bits(upr_link_cfg_t)), .DEPTH(2)) u_store
  (
    .i_clk   (i_clk),
    .i_ce    (i_ce),
    .i_we    (i_hib_enter && !hib_reg),
    .i_addr  (1'b0),
    .i_wdata (link_reg),
    .o_rdata (saved_cfg)
  );

  always_ff @(posedge i_clk)
  begin
    if (link_reset)
    begin
      link_reg    <= '0;
      hib_reg     <= 1'b0;
      restore_reg <= 1'b0;
    end
    else if (i_ce)
    begin
      restore_reg <= hib_reg && i_hib_exit;
      if (i_hib_enter && !hib_reg)
        hib_reg <= 1'b1;
      else if (hib_reg && i_hib_exit)
        hib_reg <= 1'b0;
      if (restore_reg)
        link_reg <= saved_cfg;
      else if (mode_ok)
        link_reg <= i_link_req;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------

  logic [NUM_UNITS-1:0] unit_mask;
  always_comb
  begin
    unit_mask = '0;
    for (int u = 0; u < NUM_UNITS; u++)
      unit_mask[u] = (i_tmr.unit == 8'(u));
  end

  assign tmr_ok = unit_reset_req && tmr_fmt_ok && in_act;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_ssu_done            <= 1'b0;
      o_ssu_error           <= 1'b0;
      o_tmr_done            <= 1'b0;
      o_tmr_error           <= 1'b0;
      o_cmd_reject          <= 1'b0;
      o_boot_map_unit       <= 8'h00;
      o_boot_map_valid      <= 1'b0;
      o_active_boot_unit    <= 8'h00;
      o_ref_clk_freq_select <= `UPR_REFCLK_DEFAULT;
      o_present_power_state <= 8'h00;
      o_state               <= UPR_ST_PRE_SLEEP;
      o_core_supply_off_ok  <= 1'b0;
      o_auto_sleep          <= 1'b0;
      o_discard_cache       <= 1'b0;
      o_link_cfg            <= '0;
      o_link_change_err     <= 1'b0;
      o_hibernated          <= 1'b0;
      o_queue_clear         <= '0;
      o_volatile_clear      <= 1'b1;
      o_poweron_clear       <= 1'b1;
      o_link_stack_clear    <= 1'b1;
    end
    else if (i_ce)
    begin
      o_ssu_done            <= ssu_ok;
      o_ssu_error           <= ssu_err;
      o_tmr_done            <= tmr_ok;
      o_tmr_error           <= i_tmr_valid && !tmr_ok;
      o_cmd_reject          <= cmd_reject;
      o_boot_map_unit       <= boot_hit_unit;
      o_boot_map_valid      <= boot_on;
      o_active_boot_unit    <= active_boot_reg;
      o_ref_clk_freq_select <= ref_clk_reg;
      o_present_power_state <= state_code(state_reg);
      o_state               <= state_reg;
      o_core_supply_off_ok  <= (state_reg == UPR_ST_SLEEP) || (state_reg == UPR_ST_POWERDOWN);
      o_auto_sleep          <= quiet_reg >= 32'(AUTO_SLEEP_CYC);
      o_discard_cache       <= ssu_ok && i_ssu.skip_flush;
      o_link_cfg            <= link_reg;
      o_link_change_err     <= i_dme_set_pwr_mode && series_bad;
      o_hibernated          <= hib_reg;
      o_queue_clear         <= link_reset ? {NUM_UNITS{1'b1}}
                               : (tmr_ok ? unit_mask : '0);
      o_volatile_clear      <= link_reset;
      o_poweron_clear       <= full_reset;
      o_link_stack_clear    <= link_reset;
    end
  end

endmodule

`default_nettype wire

// ==== logic/upr_map.svh ====
`ifndef UPR_MAP_SVH
`define UPR_MAP_SVH

`define UPR_BOOT_FEAT_ON      8'h01
`define UPR_BOOT_UNIT_A       8'h01
`define UPR_BOOT_UNIT_B       8'h02
`define UPR_WLUN_BOOT         8'h30
`define UPR_WLUN_DEVICE       8'hD0
`define UPR_IDN_ACTIVE_BOOT   8'h00
`define UPR_IDN_POWER_STATE   8'h02
`define UPR_IDN_REF_CLK       8'h0A
`define UPR_SSU_OPCODE        8'h1B
`define UPR_PC_ACTIVE         4'h1
`define UPR_PC_SLEEP          4'h2
`define UPR_PC_POWERDOWN      4'h3
`define UPR_TMF_UNIT_RESET    8'h08
`define UPR_DSL_ZERO          16'h0000
`define UPR_REFCLK_DEFAULT    2'h1
`define UPR_INIT_SLEEP        8'h00
`define UPR_INIT_ACTIVE       8'h01
`define UPR_MODE_PWM          1'b0
`define UPR_AUTO_SLEEP_NS     10000000
`define UPR_CLK_PERIOD_NS     10
`define UPR_AUTO_SLEEP_CYC    (`UPR_AUTO_SLEEP_NS / `UPR_CLK_PERIOD_NS)
`define UPR_IDLE_CYC_DEFAULT  1000
`define UPR_NUM_UNITS         8

`endif

// ==== logic/upr_pkg.sv ====
`default_nettype none

package upr_pkg;

  typedef enum logic [2:0]
  {
    UPR_ST_PRE_ACTIVE    = 3'b000,
    UPR_ST_ACTIVE        = 3'b001,
    UPR_ST_IDLE          = 3'b010,
    UPR_ST_PRE_SLEEP     = 3'b011,
    UPR_ST_SLEEP         = 3'b100,
    UPR_ST_PRE_POWERDOWN = 3'b101,
    UPR_ST_POWERDOWN     = 3'b110
  } upr_state_t;

  typedef struct packed
  {
    logic [7:0] unit;
    logic       immediate_return;
    logic [3:0] power_cond;
    logic       skip_flush;
    logic       load_eject;
    logic       start;
  } upr_ssu_t;

  typedef struct packed
  {
    logic [7:0]  unit;
    logic [7:0]  task_tag;
    logic [7:0]  function_code;
    logic [15:0] data_seg_len;
  } upr_tmr_t;

  typedef struct packed
  {
    logic       hs;
    logic       series_b;
    logic [2:0] gear;
    logic [1:0] lanes;
    logic [1:0] pwr_mode;
  } upr_link_cfg_t;

endpackage

`default_nettype wire

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import upr_pkg::*;

  logic          clk, rst, pin_n, ep_rst, up_rst, pend, hib_in, hib_out, ce, clr_tog, clr_seen;
  logic [7:0]    init_st, boot_en, attr_idn, attr_d, cmd_u, bunit, abu, pstate, qclr, qseen;
  logic [7:0]    bsel [8];
  logic          attr_wr, ssu_v, tmr_v, cmd_v, cmd_w, pwr_set, ssu_done, ssu_err, tmr_done, tmr_err;
  logic          rej, bvalid, sup_off, asleep, disc, lerr, hib, vol, pon, lnk;
  logic [1:0]    refsel;
  logic [9:0]    sk;
  upr_ssu_t      ssu;
  upr_tmr_t      tmr;
  upr_link_cfg_t lreq, lcfg, saved;
  upr_state_t    st;
  int            miscompares, cmp_count;

  upr_host_model h
  (
    .i_clk(clk), .o_attr_wr(attr_wr), .o_attr_idn(attr_idn), .o_attr_wdata(attr_d), .o_ssu_valid(ssu_v),
    .o_ssu(ssu), .o_tmr_valid(tmr_v), .o_tmr(tmr), .o_cmd_valid(cmd_v), .o_cmd_unit(cmd_u),
    .o_cmd_write(cmd_w), .o_pwr_set(pwr_set), .o_link_req(lreq)
  );

  upr_ctrl #(.AUTO_SLEEP_CYC(20), .IDLE_CYC(8)) DUT
  (
    .i_clk(clk), .i_rst(rst), .i_ce(ce), .i_rst_pin_n(pin_n), .i_endpoint_reset(ep_rst),
    .i_unipro_reset(up_rst), .i_initial_power_state(init_st), .i_boot_feature_enable(boot_en),
    .i_unit_boot_select(bsel), .i_attr_wr(attr_wr), .i_attr_idn(attr_idn), .i_attr_wdata(attr_d),
    .i_ssu_valid(ssu_v), .i_ssu(ssu), .i_tmr_valid(tmr_v), .i_tmr(tmr), .i_cmd_valid(cmd_v),
    .i_cmd_unit(cmd_u), .i_cmd_write(cmd_w), .i_task_pending(pend), .i_dme_set_pwr_mode(pwr_set),
    .i_link_req(lreq), .i_hib_enter(hib_in), .i_hib_exit(hib_out), .o_ssu_done(ssu_done),
    .o_ssu_error(ssu_err), .o_tmr_done(tmr_done), .o_tmr_error(tmr_err), .o_cmd_reject(rej),
    .o_boot_map_unit(bunit), .o_boot_map_valid(bvalid), .o_active_boot_unit(abu),
    .o_ref_clk_freq_select(refsel), .o_present_power_state(pstate), .o_state(st),
    .o_core_supply_off_ok(sup_off), .o_auto_sleep(asleep), .o_discard_cache(disc), .o_link_cfg(lcfg),
    .o_link_change_err(lerr), .o_hibernated(hib), .o_queue_clear(qclr), .o_volatile_clear(vol),
    .o_poweron_clear(pon), .o_link_stack_clear(lnk)
  );

  // Pulses are caught here so a check never depends on hitting the exact cycle.
  always @(posedge clk)
  begin
    clr_seen <= clr_tog;
    sk       <= (clr_tog != clr_seen ? '0 : sk)
                | {disc, ssu_done, ssu_err, tmr_done, tmr_err, rej, lerr, vol, pon, lnk};
    qseen    <= (clr_tog != clr_seen ? '0 : qseen) | qclr;
  end

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic clr();
    clr_tog = ~clr_tog;
  endtask

  task automatic wst(input upr_state_t s, input int n);
    for (int i = 0; i < n && st !== s; i++)
      cyc(1);
    chk("state", 8'(s), 8'(st));
  endtask

  task automatic bad(input logic [7:0] u, input logic [3:0] pc, input logic [1:0] fl);
    clr();
    h.ssu(u, pc, fl);
    cyc(2);
    chk("ssu_err", 8'h01, sk[7]);
    chk("ssu_done", 8'h00, sk[8]);
  endtask

  task automatic tbad(input logic [7:0] u, input logic [7:0] f, input logic [15:0] n);
    clr();
    h.tmr(u, f, n);
    cyc(2);
    chk("tmr_err", 8'h01, sk[5]);
    chk("tmr_q", 8'h00, qseen);
  endtask

  task automatic lk(input logic hs, input logic sb, input logic err);
    upr_link_cfg_t c;
    c = {hs, sb, 3'd1, 2'd2, 2'd1};
    clr();
    h.dme(c);
    cyc(3);
    chk("lerr", 8'(err), sk[3]);
    chk("cfg_sb", 8'(sb ^ err), lcfg.series_b);
  endtask

  task automatic t_resets();
    wst(UPR_ST_PRE_SLEEP, 4);
    chk("refsel", 8'h01, refsel);
    init_st = 8'h01;
    clr();
    pin_n = 1'b0;
    cyc(2);
    pin_n = 1'b1;
    wst(UPR_ST_PRE_ACTIVE, 6);
    chk("pin_pon", 8'h01, sk[1]);
    chk("pin_vol", 8'h01, sk[2]);
    chk("pin_q", 8'hFF, qseen);
    for (int k = 0; k < 2; k++)
    begin
      clr();
      ep_rst = (k == 0);
      up_rst = (k == 1);
      cyc(1);
      {ep_rst, up_rst} = 2'b00;
      cyc(3);
      chk("ep_pon", 8'h00, sk[1]);
      chk("ep_vol", 8'h01, sk[2]);
      chk("ep_link", 8'h01, sk[0]);
      chk("ep_q", 8'hFF, qseen);
    end
  endtask

  task automatic t_active();
    h.ssu(8'hD0, 4'h1, 2'b00);
    wst(UPR_ST_ACTIVE, 10);
    chk("pstate", 8'h11, pstate);
    h.attr(8'h0A, 8'h03);
    cyc(3);
    chk("refsel", 8'h03, refsel);
    h.attr(8'h0A, 8'h00);
    cyc(3);
    chk("refsel", 8'h03, refsel);
    wst(UPR_ST_IDLE, 20);
    for (int i = 0; i < 40 && asleep !== 1'b1; i++)
      cyc(1);
    chk("auto_sleep", 8'h01, asleep);
    pend = 1'b1;
    wst(UPR_ST_ACTIVE, 6);
  endtask

  task automatic t_units();
    bad(8'hD0, 4'h0, 2'b00);
    bad(8'hD0, 4'h4, 2'b00);
    bad(8'h30, 4'h1, 2'b00);
    bad(8'hD0, 4'h1, 2'b01);
    clr();
    h.tmr(8'h03, 8'h08, 16'h0000);
    cyc(2);
    chk("tmr_done", 8'h01, sk[6]);
    chk("tmr_q", 8'h08, qseen);
    chk("tmr_vol", 8'h00, sk[2]);
    chk("boot_off", 8'h00, bvalid);
    tbad(8'h03, 8'h01, 16'h0000);
    tbad(8'h03, 8'h08, 16'h0004);
  endtask

  task automatic t_link();
    lk(1'b1, 1'b0, 1'b0);
    lk(1'b1, 1'b1, 1'b1);
    lk(1'b0, 1'b1, 1'b0);
    lk(1'b1, 1'b1, 1'b0);
    saved  = lcfg;
    hib_in = 1'b1;
    cyc(1);
    hib_in = 1'b0;
    cyc(2);
    chk("hib", 8'h01, hib);
    ce      = 1'b0;
    hib_out = 1'b1;
    cyc(2);
    chk("ce_hold", 8'h01, hib);
    ce      = 1'b1;
    cyc(1);
    hib_out = 1'b0;
    cyc(3);
    chk("cfg_kept", 8'h01, 8'(saved === lcfg));
  endtask

  task automatic t_boot();
    boot_en = 8'h01;
    bsel[2] = 8'h01;
    bsel[5] = 8'h02;
    h.attr(8'h00, 8'h02);
    cyc(3);
    chk("abu", 8'h02, abu);
    chk("map", 8'h05, bunit);
    chk("map_v", 8'h01, bvalid);
    h.attr(8'h00, 8'h01);
    cyc(3);
    chk("map", 8'h02, bunit);
    clr();
    h.cmd(8'h30, 1'b1);
    cyc(2);
    chk("rej", 8'h01, sk[4]);
  endtask

  task automatic t_sleep();
    wst(UPR_ST_ACTIVE, 6);
    pend = 1'b0;
    clr();
    h.ssu(8'hD0, 4'h2, 2'b00);
    wst(UPR_ST_SLEEP, 6);
    chk("supply_off", 8'h01, sup_off);
    chk("discard", 8'h00, sk[9]);
    tbad(8'h01, 8'h08, 16'h0000);
    clr();
    h.ssu(8'hD0, 4'h3, 2'b10);
    wst(UPR_ST_POWERDOWN, 6);
    chk("discard", 8'h01, sk[9]);
    bad(8'hD0, 4'h2, 2'b00);
    h.ssu(8'hD0, 4'h1, 2'b00);
    wst(UPR_ST_PRE_ACTIVE, 4);
    wst(UPR_ST_ACTIVE, 4);
  endtask

  task automatic conclude();
    $display("compares %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    {rst, pin_n, ce, clr_tog, ep_rst, up_rst, pend, hib_in, hib_out} = 9'b111000000;
    {init_st, boot_en} = '0;
    for (int i = 0; i < 8; i++)
      bsel[i] = 8'h00;
    miscompares = 0;
    cmp_count   = 0;
    cyc(8);
    rst = 1'b0;
    t_resets();
    t_active();
    t_boot();
    t_units();
    t_link();
    t_sleep();
    conclude();
  end

  initial
  begin
    #200000;
    miscompares++;
    conclude();
  end
endmodule

`default_nettype wire

// ==== verification/upr_chk.sv ====
`timescale 1ns/1ps
`default_nettype none

module upr_chk
(
  input wire logic                i_clk,
  input wire logic                i_rst,
  input wire logic                i_ce,
  input wire logic                i_ssu_valid,
  input wire upr_pkg::upr_ssu_t   i_ssu,
  input wire logic                i_tmr_valid,
  input wire upr_pkg::upr_tmr_t   i_tmr,
  input wire logic                o_ssu_done,
  input wire logic                o_ssu_error,
  input wire logic                o_tmr_error,
  input wire upr_pkg::upr_state_t o_state
);
  import upr_pkg::*;

  logic ssu_take;
  logic tmr_take;

  assign ssu_take = i_ce && i_ssu_valid;
  assign tmr_take = i_ce && i_tmr_valid;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  // ------------------------------------------
  // Power mode walks
  // ------------------------------------------
  // The transit state must show for exactly one cycle, or a host polling it could miss the step.
  sequence s_via(upr_state_t mid, upr_state_t last);
    ##1 o_state == mid ##1 o_state == last;
  endsequence

  property p_walk(logic [3:0] pc, upr_state_t mid, upr_state_t last);
    o_ssu_done && $past(i_ssu.power_cond) == pc |-> s_via(mid, last);
  endproperty

  a_sleep_walk: assert property (p_walk(4'h2, UPR_ST_PRE_SLEEP, UPR_ST_SLEEP))
    else $error("sleep entry skipped pre-sleep");
  a_pd_walk: assert property (p_walk(4'h3, UPR_ST_PRE_POWERDOWN, UPR_ST_POWERDOWN))
    else $error("powerdown entry skipped pre-powerdown");
  a_idle_source: assert property (
    o_state == UPR_ST_IDLE && $past(o_state) != UPR_ST_IDLE |-> $past(o_state) == UPR_ST_ACTIVE)
    else $error("idle entered from a state other than active");

  // ------------------------------------------
  // Request refusals
  // ------------------------------------------
  a_bad_cond: assert property (
    ssu_take && (i_ssu.power_cond == 4'h0 || i_ssu.power_cond > 4'h3) |=> o_ssu_error && !o_ssu_done)
    else $error("bad power condition not refused");
  a_wrong_unit: assert property (ssu_take && i_ssu.unit != 8'hD0 |=> o_ssu_error)
    else $error("power change to wrong unit not refused");
  a_eject_set: assert property (ssu_take && i_ssu.load_eject |=> o_ssu_error)
    else $error("load eject set not refused");
  a_tmr_func: assert property (tmr_take && i_tmr.function_code != 8'h08 |=> o_tmr_error)
    else $error("unknown task function not refused");
  a_tmr_length: assert property (tmr_take && i_tmr.data_seg_len != 16'h0000 |=> o_tmr_error)
    else $error("nonzero segment length not refused");
endmodule

bind upr_ctrl upr_chk u_chk
(
  .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_ssu_valid(i_ssu_valid), .i_ssu(i_ssu),
  .i_tmr_valid(i_tmr_valid), .i_tmr(i_tmr), .o_ssu_done(o_ssu_done), .o_ssu_error(o_ssu_error),
  .o_tmr_error(o_tmr_error), .o_state(o_state)
);

`default_nettype wire

// ==== verification/upr_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// Host side: every request is raised just after an edge and taken at the next one.
module upr_host_model
(
  input  wire logic              i_clk,
  output logic                   o_attr_wr,
  output logic [7:0]             o_attr_idn,
  output logic [7:0]             o_attr_wdata,
  output logic                   o_ssu_valid,
  output upr_pkg::upr_ssu_t      o_ssu,
  output logic                   o_tmr_valid,
  output upr_pkg::upr_tmr_t      o_tmr,
  output logic                   o_cmd_valid,
  output logic [7:0]             o_cmd_unit,
  output logic                   o_cmd_write,
  output logic                   o_pwr_set,
  output upr_pkg::upr_link_cfg_t o_link_req
);
  import upr_pkg::*;

  initial
  begin
    {o_attr_wr, o_ssu_valid, o_tmr_valid, o_cmd_valid, o_pwr_set} = '0;
    {o_attr_idn, o_attr_wdata, o_cmd_unit, o_cmd_write} = '0;
    o_ssu      = '0;
    o_tmr      = '0;
    o_link_req = '0;
  end

  task automatic step();
    @(posedge i_clk);
    #1;
  endtask

  // Released payloads are inverted (attr keeps its IDN, cmd its write flag) and strobes drop so stale data can never pass for a request.
  task automatic attr(input logic [7:0] idn, input logic [7:0] d);
    step();
    o_attr_idn   = idn;
    o_attr_wdata = d;
    o_attr_wr    = 1'b1;
    step();
    o_attr_wr    = 1'b0;
    o_attr_wdata = ~d;
  endtask

  task automatic ssu(input logic [7:0] u, input logic [3:0] pc, input logic [1:0] fl);
    step();
    o_ssu       = {u, 1'b0, pc, fl, 1'b1};
    o_ssu_valid = 1'b1;
    step();
    o_ssu_valid = 1'b0;
    o_ssu       = ~o_ssu;
  endtask

  task automatic tmr(input logic [7:0] u, input logic [7:0] f, input logic [15:0] n);
    step();
    o_tmr       = {u, 8'h5A, f, n};
    o_tmr_valid = 1'b1;
    step();
    o_tmr_valid = 1'b0;
    o_tmr       = ~o_tmr;
  endtask

  task automatic cmd(input logic [7:0] u, input logic w);
    step();
    o_cmd_unit  = u;
    o_cmd_write = w;
    o_cmd_valid = 1'b1;
    step();
    o_cmd_valid = 1'b0;
    o_cmd_unit  = ~u;
  endtask

  task automatic dme(input upr_link_cfg_t c);
    step();
    o_link_req = c;
    o_pwr_set  = 1'b1;
    step();
    o_pwr_set  = 1'b0;
    o_link_req = ~c;
  endtask
endmodule

`default_nettype wire
